// [sed_pkg.sv]
// Purpose: Shared constants and types for the stream entry decode block.
// Assumes: AXI4-Lite register access with 32-bit data words.
// Notes:   Entry word layout is used by the decode block; register offsets by it and the bench.
package sed_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_ENTRY_LO = 8'h00;
    localparam logic [7:0] OFF_ENTRY_HI = 8'h04;
    localparam logic [7:0] OFF_SELECT   = 8'h08;
    localparam logic [7:0] OFF_CONTROL  = 8'h0c;
    localparam logic [7:0] OFF_REQUEST  = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;
    localparam logic [7:0] OFF_ADDR_LO  = 8'h18;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h1c;
    localparam logic [7:0] OFF_LEAF     = 8'h20;

    // Field positions inside the low entry word.
    localparam int ENT_VALID   = 0;
    localparam int ENT_CFG_LSB = 1;
    localparam int ENT_FMT_LSB = 4;
    localparam int ENT_CNT_LSB = 6;
    localparam int ENT_ATS_LSB = 11;
    localparam int ENT_STAGE2_FORMAT_64BIT  = 13;

    // Control register bit positions and value after reset.
    localparam int CTL_CHECK  = 0;
    localparam int CTL_S2P    = 1;
    localparam int CTL_SECURE_STAGE2_SUPPORT   = 2;
    localparam int CTL_S1P    = 3;
    localparam int CTL_EI     = 4;
    localparam int CTL_SECURE = 5;
    localparam logic [5:0] CTL_RESET = 6'h0e;

    // Status register bit positions and the request substream field position.
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_EV_TREQ = 2;
    localparam int ST_EV_FORB = 3;
    localparam int ST_RES_LSB = 4;
    localparam int ST_S1      = 6;
    localparam int ST_S2      = 7;
    localparam int ST_TWO_LVL = 8;
    localparam int ST_INVALID = 9;
    localparam int REQ_SSID_LSB = 4;

    // Stream configuration and table format codes.
    localparam logic [2:0] CFG_BYPASS = 3'h4;
    localparam logic [1:0] FMT_L2_4K  = 2'h1;
    localparam logic [1:0] FMT_L2_64K = 2'h2;
    localparam int LEAF_4K_BITS  = 6;
    localparam int LEAF_64K_BITS = 10;
    localparam int CD_SHIFT      = 6;
    localparam int L1_SHIFT      = 3;
    localparam int ADDR_W        = 38;

    // Transaction kinds carried in the request register.
    localparam logic [1:0] KIND_PLAIN  = 2'h0;
    localparam logic [1:0] KIND_ATS    = 2'h1;
    localparam logic [1:0] KIND_TRANSL = 2'h2;

    // Verdict outcomes.
    typedef enum logic [1:0] {RES_FORWARD, RES_ABORT, RES_UR, RES_CA} sed_res_t;

    // Decision handed to the forwarding logic.
    typedef struct packed {
        sed_res_t            res;
        logic                invalid;
        logic                s1_en;
        logic                s2_en;
        logic                ev_bad_treq;
        logic                ev_forbidden;
        logic                two_level;
        logic [ADDR_W-1:0]   cd_addr;
        logic [9:0]          leaf_idx;
    } sed_verdict_t;

endpackage

// [sed_entry_store.sv]
// Purpose: Small storage for stream table entries, two words each.
// Assumes: One write port per word half, one registered read port.
// Notes:   Read data lag the read index by one clock.
`timescale 1ns/1ps
module sed_entry_store #(
    parameter int ENTRIES = 4,
    parameter int IDX_W   = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             we_lo,
    input  wire logic             we_hi,
    input  wire logic [IDX_W-1:0] idx,
    input  wire logic [31:0]      wdata,
    output logic      [31:0]      rd_lo,
    output logic      [31:0]      rd_hi
);
    import sed_pkg::*;

    logic [31:0] lo_mem [ENTRIES];
    logic [31:0] hi_mem [ENTRIES];

    // Storage writes; the array itself carries no reset.
    always_ff @(posedge aclk) begin
        if (we_lo) lo_mem[idx] <= wdata;
        if (we_hi) hi_mem[idx] <= wdata;
    end

    // Registered read of the selected entry.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_lo <= 32'h0;
            rd_hi <= 32'h0;
        end else begin
            rd_lo <= lo_mem[idx];
            rd_hi <= hi_mem[idx];
        end
    end
endmodule

// [sed_decode.sv]
// Purpose: Stream table entry decode with AXI4-Lite register access.
// Assumes: Single clock aclk, synchronous active-low reset aresetn.
// Notes:   A request is decided three clocks after its register write.
// Overview of operation
// - Configuration 0b0xx blocks traffic with an abort and no event.
// - Configuration 0b100 passes traffic with both stages bypassed.
// - Configuration bits pick stage 1, stage 2 or both translating.
// - Without stage 2, configurations 0b11x make the entry illegal.
// - Secure entry 0b11x without secure stage 2 support is illegal.
// - Secure entry 0b11x with the 64-bit stage 2 flag clear is illegal.
// - Bypass denies ATS requests, and translated traffic when checking.
// - Bypass ignores the ATS enable field of the entry.
// - Bypass denials record bad request or translated-forbidden events.
// - Configuration 0b000 answers ATS requests with UR, no event.
// - Configuration 0b000 with checking aborts translated traffic silently.
// - Embedded storage without stage 1 reads stage 1 enable as zero.
// - Embedded storage without stage 2 reads stage 2 enable as zero.
// - Zero substream count points at one descriptor, ignoring format.
// - Linear table is indexed by substream bits count-1 down to 0.
// - Linear table pointer bits count+5 down to 6 are taken as zero.
// - Format 0b01 selects two-level tables with 4KB leaves.
// - Entry valid bit clear makes the entry invalid, others ignored.
// - Illegal entries behave exactly as entries with valid clear.
// - 4KB leaf tables are indexed by substream bits 5 down to 0.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module sed_decode #(
    parameter int ENTRIES = 4,
    parameter int SSID_W  = 20
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [7:0]           araddr,
    input  wire logic [2:0]           arprot,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    output sed_pkg::sed_verdict_t     verdict,
    output logic                      verdict_valid
);
    import sed_pkg::*;

    localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

    // Refuse shapes the decode logic cannot serve.
    if (ENTRIES < 1 || ENTRIES > 256 || SSID_W < 1 || SSID_W > 20) begin : g_bad
        $error("sed_decode: ENTRIES or SSID_W out of range");
    end

    typedef enum {S_IDLE, S_FETCH, S_DECIDE} sed_state_t;

    // Byte-lane merge of a write into an older word.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    // Mask with the n lowest address bits set.
    function automatic logic [ADDR_W-1:0] low_mask(input int n);
        logic [ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < ADDR_W; i++) m[i] = (i < n);
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic              aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [7:0]        aw_addr_q;
    logic [31:0]       w_data_q, rdata_q;
    logic [3:0]        w_strb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [IDX_W-1:0]  sel_q;
    logic [5:0]        ctrl_q;
    logic [1:0]        kind_q;
    logic [SSID_W-1:0] ssid_q;
    logic              done_q, ev_treq_q, ev_forb_q, vvalid_q;
    sed_verdict_t      verdict_q;
    sed_state_t        state_q;
    logic [31:0]       ent_lo, ent_hi;

    ////////////////////////////////////////////////////////////////////////
    // Write channel decode.
    wire        do_write = aw_held_q & w_held_q & ~bvalid_q;
    wire [31:0] wmerged_lo = merge(ent_lo, w_data_q, w_strb_q);
    wire [31:0] wmerged_hi = merge(ent_hi, w_data_q, w_strb_q);
    wire        hit_lo  = aw_addr_q == OFF_ENTRY_LO;
    wire        hit_hi  = aw_addr_q == OFF_ENTRY_HI;
    wire        hit_sel = aw_addr_q == OFF_SELECT;
    wire        hit_ctl = aw_addr_q == OFF_CONTROL;
    wire        hit_req = aw_addr_q == OFF_REQUEST;
    wire        hit_st  = aw_addr_q == OFF_STATUS;
    wire        w_mapped = hit_lo | hit_hi | hit_sel | hit_ctl | hit_req
                         | hit_st;
    wire        start = do_write & hit_req & (state_q == S_IDLE);
    wire        w1c_done = do_write & hit_st & w_strb_q[0] & w_data_q[ST_DONE];
    wire        w1c_treq = do_write & hit_st & w_strb_q[0]
                         & w_data_q[ST_EV_TREQ];
    wire        w1c_forb = do_write & hit_st & w_strb_q[0]
                         & w_data_q[ST_EV_FORB];
    wire        ei_no_s1 = ctrl_q[CTL_EI] & ~ctrl_q[CTL_S1P];
    wire        ei_no_s2 = ctrl_q[CTL_EI] & ~ctrl_q[CTL_S2P];
    // Embedded storage drops enable bits of stages that are absent.
    wire [31:0] store_lo = wmerged_lo
                         & ~({31'h0, ei_no_s1} << (ENT_CFG_LSB))
                         & ~({31'h0, ei_no_s2} << (ENT_CFG_LSB + 1));

    assign awready = ~aw_held_q;
    assign wready  = ~w_held_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;

    // Address and data are caught in either order, answered after both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else begin
            if (awvalid & ~aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid & ~w_held_q) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= w_mapped ? 2'h0 : 2'h2;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Software-owned selection, control and request fields.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q  <= '0;
            ctrl_q <= CTL_RESET;
            kind_q <= KIND_PLAIN;
            ssid_q <= '0;
        end else begin
            if (do_write & hit_sel & w_strb_q[0]) sel_q <= w_data_q[IDX_W-1:0];
            if (do_write & hit_ctl & w_strb_q[0]) ctrl_q <= w_data_q[5:0];
            if (start) begin
                kind_q <= w_data_q[1:0];
                ssid_q <= w_data_q[REQ_SSID_LSB +: SSID_W];
            end
        end
    end

    // Entry storage for the selected stream.
    sed_entry_store #(
        .ENTRIES (ENTRIES),
        .IDX_W   (IDX_W)
    ) u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we_lo   (do_write & hit_lo),
        .we_hi   (do_write & hit_hi),
        .idx     (sel_q),
        .wdata   (hit_lo ? store_lo : wmerged_hi),
        .rd_lo   (ent_lo),
        .rd_hi   (ent_hi)
    );

    ////////////////////////////////////////////////////////////////////////
    // Entry field decode and legality.
    wire [2:0] ent_cfg = ent_lo[ENT_CFG_LSB +: 3];
    wire [1:0] ent_fmt = ent_lo[ENT_FMT_LSB +: 2];
    wire [4:0] ent_cnt = ent_lo[ENT_CNT_LSB +: 5];
    wire [1:0] ent_ats = ent_lo[ENT_ATS_LSB +: 2];
    wire       s2_cfg  = ent_cfg[2:1] == 2'h3;
    wire       secure  = ctrl_q[CTL_SECURE];
    wire       illegal = s2_cfg & (~ctrl_q[CTL_S2P]
                       | (secure & ~ctrl_q[CTL_SECURE_STAGE2_SUPPORT])
                       | (secure & ~ent_lo[ENT_STAGE2_FORMAT_64BIT]));
    wire       ent_ok  = ent_lo[ENT_VALID] & ~illegal;
    wire       is_off  = ent_ok & ~ent_cfg[2];
    wire       is_byp  = ent_ok & (ent_cfg == CFG_BYPASS);
    wire       is_xl   = ent_ok & ent_cfg[2] & ~is_byp;
    wire       check   = ctrl_q[CTL_CHECK];
    wire       k_ats   = kind_q == KIND_ATS;
    wire       k_tr    = kind_q == KIND_TRANSL;
    wire       k_pl    = ~k_ats & ~k_tr;

    // Outcome per kind; bypass never looks at the ATS enable field.
    wire sed_res_t res_pl = ent_cfg[2] & ent_ok ? RES_FORWARD : RES_ABORT;
    wire sed_res_t res_ats = ~ent_ok ? RES_CA
                           : (is_off | is_byp) ? RES_UR
                           : (ent_ats != 2'h0) ? RES_FORWARD : RES_UR;
    wire sed_res_t res_tr = ~ent_ok ? RES_ABORT
                          : (check & (is_off | is_byp)) ? RES_ABORT
                          : RES_FORWARD;
    wire ev_treq = k_ats & ent_ok & ~is_off
                 & (is_byp | (ent_ats == 2'h0));
    wire ev_forb = k_tr & check & is_byp;

    ////////////////////////////////////////////////////////////////////////
    // Context descriptor address.
    wire [ADDR_W-1:0] ptr_b  = {ent_hi, 6'h00};
    wire [ADDR_W-1:0] ssid_x = {{(ADDR_W-SSID_W){1'b0}}, ssid_q};
    wire [ADDR_W-1:0] sub    = ssid_x & low_mask(int'(ent_cnt));
    wire [ADDR_W-1:0] lin    = (ptr_b & ~low_mask(int'(ent_cnt) + CD_SHIFT))
                             | (sub << CD_SHIFT);
    wire              two_lvl = (ent_cnt != 5'h0)
                              & ((ent_fmt == FMT_L2_4K)
                              | (ent_fmt == FMT_L2_64K));
    wire [4:0]        leaf_n  = (ent_fmt == FMT_L2_4K) ? 5'(LEAF_4K_BITS)
                                                       : 5'(LEAF_64K_BITS);
    wire [ADDR_W-1:0] l1_base = (int'(ent_cnt) > int'(leaf_n) + L1_SHIFT)
                        ? ptr_b & ~low_mask(int'(ent_cnt) - int'(leaf_n)
                                            + L1_SHIFT)
                        : ptr_b;
    wire [ADDR_W-1:0] l1_addr = l1_base + ((sub >> leaf_n) << L1_SHIFT);
    wire [ADDR_W-1:0] leaf_m  = sub & low_mask(int'(leaf_n));
    wire [ADDR_W-1:0] cd_addr = (ent_cnt == 5'h0) ? ptr_b
                              : two_lvl ? l1_addr : lin;

    sed_verdict_t verdict_d;
    assign verdict_d.res = k_ats ? res_ats : k_tr ? res_tr : res_pl;
    assign verdict_d.invalid      = ~ent_ok;
    assign verdict_d.s1_en        = is_xl & ent_cfg[0];
    assign verdict_d.s2_en        = is_xl & ent_cfg[1];
    assign verdict_d.ev_bad_treq  = ev_treq;
    assign verdict_d.ev_forbidden = ev_forb;
    assign verdict_d.two_level    = two_lvl;
    assign verdict_d.cd_addr      = cd_addr;
    assign verdict_d.leaf_idx     = two_lvl ? leaf_m[9:0] : 10'h0;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch the entry, decide, then publish.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= S_IDLE;
            verdict_q <= '0;
            vvalid_q  <= 1'b0;
        end else begin
            vvalid_q <= 1'b0;
            unique case (state_q)
                S_IDLE:   if (start) state_q <= S_FETCH;
                S_FETCH:  state_q <= S_DECIDE;
                S_DECIDE: begin
                    verdict_q <= verdict_d;
                    vvalid_q  <= 1'b1;
                    state_q   <= S_IDLE;
                end
            endcase
        end
    end

    // Sticky status flags; a new event wins over a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q    <= 1'b0;
            ev_treq_q <= 1'b0;
            ev_forb_q <= 1'b0;
        end else begin
            done_q    <= vvalid_q | (done_q & ~w1c_done);
            ev_treq_q <= (vvalid_q & verdict_q.ev_bad_treq)
                       | (ev_treq_q & ~w1c_treq);
            ev_forb_q <= (vvalid_q & verdict_q.ev_forbidden)
                       | (ev_forb_q & ~w1c_forb);
        end
    end

    assign verdict       = verdict_q;
    assign verdict_valid = vvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // Read channel.
    wire [31:0] status_w = {22'h0, verdict_q.invalid, verdict_q.two_level,
                            verdict_q.s2_en, verdict_q.s1_en,
                            verdict_q.res, ev_forb_q, ev_treq_q, done_q,
                            state_q != S_IDLE};
    wire [31:0] rmux = (araddr == OFF_ENTRY_LO) ? ent_lo
                     : (araddr == OFF_ENTRY_HI) ? ent_hi
                     : (araddr == OFF_SELECT)   ? 32'(sel_q)
                     : (araddr == OFF_CONTROL)  ? {26'h0, ctrl_q}
                     : (araddr == OFF_REQUEST)  ? 32'h0
                     : (araddr == OFF_STATUS)   ? status_w
                     : (araddr == OFF_ADDR_LO)  ? verdict_q.cd_addr[31:0]
                     : (araddr == OFF_ADDR_HI)  ? {26'h0,
                                                  verdict_q.cd_addr[37:32]}
                     : (araddr == OFF_LEAF)     ? {22'h0, verdict_q.leaf_idx}
                     : 32'h0;
    wire r_mapped = araddr <= OFF_LEAF && araddr[1:0] == 2'h0;

    assign arready = ~rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // One read at a time, answered the clock after its address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= 2'h0;
        end else if (arvalid & ~rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rmux;
            rresp_q  <= r_mapped ? 2'h0 : 2'h2;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the decided verdict.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence decide_s;
        state_q == S_DECIDE;
    endsequence
    sequence walk_s;
        state_q == S_FETCH ##1 state_q == S_DECIDE ##1 vvalid_q;
    endsequence

    order_walk_a: assert property (start |=> walk_s)
        else $error("verdict not published two clocks after fetch");
    abort_cfg_a: assert property (decide_s and is_off and k_pl |=>
        verdict.res == RES_ABORT && !verdict.ev_bad_treq)
        else $error("disabled stream did not abort silently");
    bypass_pass_a: assert property (decide_s and is_byp and k_pl |=>
        verdict.res == RES_FORWARD && !verdict.s1_en && !verdict.s2_en)
        else $error("bypass stream not forwarded untranslated");
    stage_sel_a: assert property (decide_s and is_xl |=>
        verdict.s1_en == $past(ent_cfg[0])
        && verdict.s2_en == $past(ent_cfg[1]))
        else $error("stage enables do not follow configuration");
    no_stage2_a: assert property (decide_s and s2_cfg and !ctrl_q[CTL_S2P]
        |=> verdict.invalid)
        else $error("stage 2 entry accepted without stage 2");
    sec_stage2_a: assert property (decide_s and s2_cfg and secure
        and (!ctrl_q[CTL_SECURE_STAGE2_SUPPORT] or !ent_lo[ENT_STAGE2_FORMAT_64BIT]) |=> verdict.invalid)
        else $error("illegal secure stage 2 entry accepted");
    bypass_ats_a: assert property (decide_s and is_byp and k_ats |=>
        verdict.res == RES_UR && verdict.ev_bad_treq ##1 ev_treq_q)
        else $error("bypass ATS request not denied with event");
    bypass_tr_a: assert property (decide_s and is_byp and k_tr and check
        |=> verdict.res == RES_ABORT && verdict.ev_forbidden)
        else $error("bypass translated traffic not refused with event");
    off_ats_a: assert property (decide_s and is_off and k_ats |=>
        verdict.res == RES_UR && !verdict.ev_bad_treq)
        else $error("disabled stream ATS request not UR");
    off_tr_a: assert property (decide_s and is_off and k_tr and check
        |=> verdict.res == RES_ABORT && !verdict.ev_forbidden)
        else $error("disabled stream translated traffic not aborted");
    invalid_a: assert property (decide_s and !ent_ok and !k_ats
        |=> verdict.res == RES_ABORT && !verdict.s1_en)
        else $error("invalid entry did not abort");
    single_cd_a: assert property (decide_s and ent_cnt == 5'h0
        |=> verdict.cd_addr == $past(ptr_b) && !verdict.two_level)
        else $error("single descriptor address wrong");
endmodule

// [sed_dev_model.sv]
// Purpose: Upstream device model that takes each verdict for its request.
// Assumes: Verdicts arrive as one-cycle pulses on aclk.
// Notes:   Result code and event bits are registered, one clock behind the verdict.
`timescale 1ns/1ps
module sed_dev_model (
    input  wire logic                  aclk,
    input  wire sed_pkg::sed_verdict_t verdict,
    input  wire logic                  verdict_valid,
    output logic [3:0]                 outcome,
    output logic                       outcome_valid
);
    import sed_pkg::*;
    // Latches the answer that the device sees for its transaction.
    always_ff @(posedge aclk) begin
        outcome_valid <= verdict_valid;
        outcome       <= {verdict.res, verdict.ev_bad_treq,
                          verdict.ev_forbidden};
    end
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the stream entry decode block.
// Assumes: Registers are reached by AXI4-Lite tasks, one access at a time.
// Notes:   Expected outcomes are queued before each request is written.
`timescale 1ns/1ps
module tb;
    import sed_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, p;
    logic [37:0] rd;
    logic [1:0] bresp, rresp, rs, ats;
    logic [3:0] outcome, ex, expq[$];
    logic outcome_valid, verdict_valid;
    logic [19:0] s;
    logic [5:0] ctl [4] = '{6'h0f, 6'h0d, 6'h2f, 6'h14};
    logic [2:0] m;
    sed_verdict_t verdict;
    int num_errors = 0, n_compared = 0, i, c, k;
    sed_decode dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .verdict(verdict),
        .verdict_valid(verdict_valid));
    sed_dev_model model (.aclk(aclk), .verdict(verdict),
        .verdict_valid(verdict_valid), .outcome(outcome),
        .outcome_valid(outcome_valid));
    // Free-running 10 MHz clock.
    initial forever #50 aclk = ~aclk;
    task automatic chk(input logic [37:0] got, input logic [37:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        // A verdict that never came back leaves its note behind.
        if (expq.size() != 0) num_errors++;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(38'(bresp), 38'h0);
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = 38'(rdata);
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Outcome for an entry; the 64-bit stage 2 flag is never set here.
    function automatic logic [3:0] expect_of(input logic [3:0] e,
        input logic [1:0] k, input logic [5:0] t, input logic [1:0] a);
        if (e[3] || (e[2:1] == 2'h3 && (!t[1] || t[5])))
            return k == KIND_ATS ? {RES_CA, 2'h0} : {RES_ABORT, 2'h0};
        if (!e[2]) return k == KIND_ATS ? {RES_UR, 2'h0} :
            (k == KIND_TRANSL && !t[0]) ? {RES_FORWARD, 2'h0} : {RES_ABORT, 2'h0};
        if (e[1:0] == 2'h0) return k == KIND_ATS ? {RES_UR, 2'h2} :
            (k == KIND_TRANSL && t[0]) ? {RES_ABORT, 2'h1} : {RES_FORWARD, 2'h0};
        return (k == KIND_ATS && a == 2'h0) ? {RES_UR, 2'h2} : {RES_FORWARD, 2'h0};
    endfunction
    // Compares each outcome that the device model reports with the oldest note.
    always @(posedge aclk) begin
        if (outcome_valid === 1'b1) begin
            ex = expq.pop_front();
            chk(38'(outcome), 38'(ex));
        end
    end
    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        summarize();
    end
    // Main sequence: reset, decode table, linear table address, bad address.
    initial begin
        void'($urandom(84));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(OFF_CONTROL);
        chk(rd, 38'(CTL_RESET));
        $display("reset values done");
        // A defined pointer keeps the descriptor address known.
        p = $urandom;
        wr(OFF_ENTRY_HI, p);
        for (i = 0; i < 4; i++) begin
            wr(OFF_CONTROL, 32'(ctl[i]));
            // Embedded storage drops the enables of absent stages.
            m = ~{1'b0, ctl[i][4] & ~ctl[i][1], ctl[i][4] & ~ctl[i][3]};
            for (c = 0; c < 9; c++) begin
                ats = 2'($urandom);
                wr(OFF_ENTRY_LO, {19'h0, ats, 7'h0, c[2:0] & m, c < 8});
                for (k = 0; k < 3; k++) begin
                    s = 20'($urandom);
                    expq.push_back(expect_of({c == 8, c[2:0] & m}, k[1:0],
                                             ctl[i], ats));
                    wr(OFF_REQUEST, {8'h0, s, 2'h0, k[1:0]});
                end
            end
        end
        repeat (4) @(posedge aclk);
        rd_reg(OFF_STATUS);
        chk(38'(rd[3:2]), 38'h3);
        $display("decode table done");
        p = $urandom;
        s = 20'($urandom);
        wr(OFF_ENTRY_HI, p);
        wr(OFF_ENTRY_LO, 32'h88b);
        expq.push_back({RES_FORWARD, 2'h0});
        wr(OFF_REQUEST, {8'h0, s, 4'h0});
        repeat (4) @(posedge aclk);
        rd_reg(OFF_ADDR_LO);
        chk(rd, 38'({p[25:2], s[1:0], 6'h0}));
        $display("linear table done");
        // Two-level table with 4KB leaves and eight substream bits.
        s = 20'($urandom);
        wr(OFF_ENTRY_LO, 32'ha1b);
        expq.push_back({RES_FORWARD, 2'h0});
        wr(OFF_REQUEST, {8'h0, s, 4'h0});
        repeat (4) @(posedge aclk);
        rd_reg(OFF_ADDR_LO);
        chk(rd, 38'({p[25:0], 1'b0, s[7:6], 3'h0}));
        rd_reg(OFF_LEAF);
        chk(rd, 38'(s[5:0]));
        $display("two-level table done");
        rd_reg(8'h24);
        chk(38'(rs), 38'h2);
        $display("unmapped read done");
        summarize();
    end
endmodule
